// *** lrc_pkg.sv ***
// lrc_pkg: constants and carrier types for the lfsr random / crc16 block
// assumes an apb slave with 32-bit data, one register per aligned word
package lrc_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [11:0] LRC_SEED_LOW_OFS = 12'h000;
	localparam logic [11:0] LRC_CRC_HIGH_OFS = 12'h004;
	localparam logic [11:0] LRC_RUN_CTRL_OFS = 12'h008;
	// ************************************************************
	// fields and reset values
	// ************************************************************
	localparam int LRC_BYTE_W = 8;
	localparam int LRC_RUN_LSB = 0;
	localparam int LRC_RUN_W = 2;
	localparam logic [15:0] LRC_LFSR_RESET = 16'hffff;
	localparam logic [15:0] LRC_POLY = 16'h8005;
	localparam int LRC_RAND_STEPS = 13;
	localparam int LRC_CRC_STEPS = 8;
	typedef enum logic [1:0] {
		LRC_RUN_AUTO = 2'b00,
		LRC_RUN_STEP = 2'b01,
		LRC_RUN_RSVD = 2'b10,
		LRC_RUN_OFF = 2'b11
	} lrc_run_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} lrc_apb_req_t;
	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} lrc_apb_rsp_t;
endpackage

// *** lrc_step.sv ***
// lrc_step: combinational n-step advance of the crc16 lfsr
// assumes msb-first galois form, shifting toward bit 15
`timescale 1ns/1ps
`default_nettype none
module lrc_step #(
	parameter int STEPS = 1
) (
	input wire logic [15:0] state_i,
	input wire logic [7:0] data_i,
	input wire logic use_data_i,
	output logic [15:0] state_o
);
	import lrc_pkg::*;
	initial begin
		if (STEPS < 1 || STEPS > 16) begin
			$error("lrc_step: STEPS out of range");
		end
	end
	always_comb begin
		logic [15:0] s;
		logic fb;
		s = state_i;
		fb = 1'b0;
		for (int i = 0; i < STEPS; i++) begin
			// data bits enter msb first; random mode feeds zeros
			fb = s[15] ^ (use_data_i & data_i[(7 - (i % 8))]);
			s = {s[14:0], 1'b0} ^ (fb ? LRC_POLY : 16'h0000);
		end
		state_o = s;
	end
endmodule
`default_nettype wire

// *** lrc_top.sv ***
// lrc_top: 16-bit lfsr used as pseudo-random byte source and crc16 engine
// assumes an apb master for cpu access and a sequencer that pulses rand_read_i
//
// What this block does
// - 16-bit lfsr, polynomial x^16+x^15+x^2+1, unrolling differs per operation.
// - run control 11 switches the generator off: sequencer reads do not shift, seed and crc writes still do.
// - run control 00: each sequencer read with no seed or crc write in the same cycle advances 13 steps at once.
// - low-byte write moves low byte to high byte, loads written byte low.
// - high-byte write starts a crc16 update, data taken msb first.
// - crc update absorbs a whole byte per clock, one byte per cycle.
// - run control 01 steps once, then clears itself back to 00.
// - reads return the lfsr: high byte and low byte registers.
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module lrc_top (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire lrc_pkg::lrc_apb_req_t apb_req_i,
	output lrc_pkg::lrc_apb_rsp_t apb_rsp_o,
	input wire logic rand_read_i,
	output logic [7:0] rand_byte_o,
	output logic [1:0] run_control_field_o
);
	import lrc_pkg::*;
	// ************************************************************
	// state
	// ************************************************************
	logic [15:0] lfsr_reg, lfsr_next;
	lrc_run_t run_reg, run_next;
	lrc_apb_rsp_t rsp_reg, rsp_next;
	logic [7:0] rand_reg, rand_next;
	logic [15:0] rand_adv, crc_adv, step_adv;
	logic access, take, wr, rd;
	// ************************************************************
	// lfsr advance networks
	// ************************************************************
	lrc_step #(.STEPS(LRC_RAND_STEPS)) u_rand (
		.state_i(lfsr_reg),
		.data_i(8'h00),
		.use_data_i(1'b0),
		.state_o(rand_adv)
	);
	lrc_step #(.STEPS(LRC_CRC_STEPS)) u_crc (
		.state_i(lfsr_reg),
		.data_i(apb_req_i.pwdata[7:0]),
		.use_data_i(1'b1),
		.state_o(crc_adv)
	);
	lrc_step #(.STEPS(1)) u_single (
		.state_i(lfsr_reg),
		.data_i(8'h00),
		.use_data_i(1'b0),
		.state_o(step_adv)
	);
	// one-wait apb: every access completes one cycle after its first access cycle
	assign access = apb_req_i.psel & apb_req_i.penable;
	// taken once, in the first access cycle; the wait cycle repeats
	// psel/penable and must not shift the lfsr a second time
	assign take = access & ~rsp_reg.pready;
	assign wr = take & apb_req_i.pwrite;
	assign rd = take & ~apb_req_i.pwrite;
	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		lfsr_next = lfsr_reg;
		run_next = run_reg;
		rand_next = rand_reg;
		rsp_next = '0;
		// seed and crc writes take priority over sequencer and single-step advances
		if (wr && apb_req_i.paddr == LRC_SEED_LOW_OFS) begin
			lfsr_next = {lfsr_reg[7:0], apb_req_i.pwdata[7:0]};
		end else if (wr && apb_req_i.paddr == LRC_CRC_HIGH_OFS) begin
			lfsr_next = crc_adv;
		end else if (run_reg == LRC_RUN_STEP) begin
			lfsr_next = step_adv;
			run_next = LRC_RUN_AUTO;
		end else if (run_reg == LRC_RUN_AUTO && rand_read_i) begin
			lfsr_next = rand_adv;
			rand_next = rand_adv[7:0];
		end
		// off state: step and auto branches do not fire; value held unless a seed or crc write
		if (wr && apb_req_i.paddr == LRC_RUN_CTRL_OFS) begin
			run_next = lrc_run_t'(apb_req_i.pwdata[LRC_RUN_LSB +: LRC_RUN_W]);
		end
		if (take) begin
			rsp_next.pready = 1'b1;
			case (apb_req_i.paddr)
				LRC_SEED_LOW_OFS: rsp_next.prdata = {24'h000000, lfsr_reg[7:0]};
				LRC_CRC_HIGH_OFS: rsp_next.prdata = {24'h000000, lfsr_reg[15:8]};
				LRC_RUN_CTRL_OFS: rsp_next.prdata = {30'h00000000, run_reg};
				default: rsp_next.pslverr = 1'b1;
			endcase
			if (!rd) begin
				rsp_next.prdata = '0;
			end
		end
	end
	// ************************************************************
	// registers
	// ************************************************************
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			lfsr_reg <= LRC_LFSR_RESET;
			run_reg <= LRC_RUN_AUTO;
			rand_reg <= LRC_LFSR_RESET[7:0];
			rsp_reg <= '0;
		end else begin
			lfsr_reg <= lfsr_next;
			run_reg <= run_next;
			rand_reg <= rand_next;
			rsp_reg <= rsp_next;
		end
	end
	// pready from a flop means one wait state; gate it with access so it only shows during a transfer
	assign apb_rsp_o = '{pready: rsp_reg.pready & access, pslverr: rsp_reg.pslverr,
		prdata: rsp_reg.prdata};
	assign rand_byte_o = rand_reg;
	assign run_control_field_o = run_reg;
	// ************************************************************
	// checks
	// ************************************************************
	AST_OFF_HOLDS: assert property (@(posedge clk_i) disable iff (reset_i)
		(run_reg == LRC_RUN_OFF && !wr) |=> lfsr_reg == $past(lfsr_reg))
		else $error("lfsr moved while generator off");
	AST_SEED_SHIFT: assert property (@(posedge clk_i) disable iff (reset_i)
		(wr && apb_req_i.paddr == LRC_SEED_LOW_OFS) |=>
		lfsr_reg == {$past(lfsr_reg[7:0]), $past(apb_req_i.pwdata[7:0])})
		else $error("seed write did not shift byte");
	AST_STEP_CLEARS: assert property (@(posedge clk_i) disable iff (reset_i)
		(run_reg == LRC_RUN_STEP && !(wr && apb_req_i.paddr == LRC_RUN_CTRL_OFS))
		|=> run_reg == LRC_RUN_AUTO)
		else $error("single step did not clear run control");
	AST_RAND_ADV: assert property (@(posedge clk_i) disable iff (reset_i)
		(run_reg == LRC_RUN_AUTO && rand_read_i && !wr) |=> rand_byte_o == lfsr_reg[7:0])
		else $error("random byte not from fresh lfsr");
	// ************************************************************
	// elaboration checks
	// ************************************************************
	initial begin
		if (LRC_RUN_W != 2) begin
			$error("lrc_top: run control must be two bits wide");
		end
		if (LRC_BYTE_W != 8) begin
			$error("lrc_top: byte lanes must be eight bits wide");
		end
		if (LRC_CRC_STEPS != LRC_BYTE_W) begin
			$error("lrc_top: crc must absorb one whole byte per write");
		end
		if (LRC_RAND_STEPS < 1 || LRC_RAND_STEPS > 16) begin
			$error("lrc_top: random unrolling out of range");
		end
	end
	// ************************************************************
	// sequences shared by the checks
	// ************************************************************
	sequence seq_crc_write;
		wr && apb_req_i.paddr == LRC_CRC_HIGH_OFS;
	endsequence
	sequence seq_run_write;
		wr && apb_req_i.paddr == LRC_RUN_CTRL_OFS;
	endsequence
	// wait cycle: bus still asserted, answer flop already set
	sequence seq_wait_cycle;
		access && rsp_reg.pready;
	endsequence
	// one wait state, then pready for exactly one cycle
	sequence seq_answer;
		apb_rsp_o.pready ##1 !apb_rsp_o.pready;
	endsequence
	// ************************************************************
	// further checks
	// ************************************************************
	AST_CRC_BYTE: assert property (@(posedge clk_i) disable iff (reset_i)
		seq_crc_write
		|=> lfsr_reg == $past(crc_adv))
		else $error("crc write did not absorb the byte");
	AST_WAIT_NO_SHIFT: assert property (@(posedge clk_i) disable iff (reset_i)
		seq_wait_cycle ##0 (run_reg != LRC_RUN_STEP && !rand_read_i)
		|=> $stable(lfsr_reg))
		else $error("held transfer shifted the lfsr again");
	AST_ANSWER_ONCE: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && !rsp_reg.pready)
		|=> seq_answer)
		else $error("apb answer not one cycle after the wait state");
	AST_STEP_ADV: assert property (@(posedge clk_i) disable iff (reset_i)
		(run_reg == LRC_RUN_STEP && !wr)
		|=> lfsr_reg == $past(step_adv))
		else $error("single step did not advance one position");
	AST_RUN_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
		seq_run_write
		|=> run_reg == $past(apb_req_i.pwdata[LRC_RUN_LSB +: LRC_RUN_W]))
		else $error("run control write not taken");
	AST_OFF_NO_RAND: assert property (@(posedge clk_i) disable iff (reset_i)
		(run_reg == LRC_RUN_OFF && rand_read_i)
		|=> $stable(rand_byte_o))
		else $error("sequencer read changed byte while off");
	AST_RSVD_IDLE: assert property (@(posedge clk_i) disable iff (reset_i)
		(run_reg == LRC_RUN_RSVD && !wr)
		|=> $stable(lfsr_reg))
		else $error("lfsr moved under reserved run control");
	AST_READ_LOW: assert property (@(posedge clk_i) disable iff (reset_i)
		(rd && apb_req_i.paddr == LRC_SEED_LOW_OFS)
		|=> apb_rsp_o.prdata == {24'h000000, $past(lfsr_reg[7:0])})
		else $error("low byte read does not show the lfsr");
	AST_READ_HIGH: assert property (@(posedge clk_i) disable iff (reset_i)
		(rd && apb_req_i.paddr == LRC_CRC_HIGH_OFS)
		|=> apb_rsp_o.prdata == {24'h000000, $past(lfsr_reg[15:8])})
		else $error("high byte read does not show the lfsr");
	AST_UNMAPPED: assert property (@(posedge clk_i) disable iff (reset_i)
		(take && apb_req_i.paddr != LRC_SEED_LOW_OFS
			&& apb_req_i.paddr != LRC_CRC_HIGH_OFS
			&& apb_req_i.paddr != LRC_RUN_CTRL_OFS)
		|=> apb_rsp_o.pslverr)
		else $error("unmapped access not flagged");
	AST_RAND_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
		!(run_reg == LRC_RUN_AUTO && rand_read_i)
		|=> $stable(rand_byte_o))
		else $error("random byte changed without a sequencer read");
	AST_RESET_STATE: assert property (@(posedge clk_i)
		reset_i
		|=> (lfsr_reg == LRC_LFSR_RESET && run_reg == LRC_RUN_AUTO && !apb_rsp_o.pready))
		else $error("reset state wrong");
endmodule
`default_nettype wire

// *** lrc_seq_model.sv ***
// lrc_seq_model: command sequencer stand-in issuing random-byte reads
// assumes go_i is a one-cycle request from the bench
`timescale 1ns/1ps
`default_nettype none
module lrc_seq_model (
	input wire logic clk_i,
	input wire logic go_i,
	output logic rand_read_o
);
	initial rand_read_o = 1'b0;
	// one strobe per request, launched just after an edge
	always @(posedge clk_i) begin
		rand_read_o <= go_i;
	end
endmodule
`default_nettype wire

// *** lrc_top_bench.sv ***
// lrc_top_bench: self-checking bench for lrc_top
// assumes lrc_pkg, lrc_top and lrc_seq_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module lrc_top_bench;
	import lrc_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	lrc_apb_req_t req = '0;
	lrc_apb_rsp_t rsp;
	logic go = 1'b0;
	logic rd;
	logic [7:0] rbyte;
	logic [1:0] run;
	logic [32:0] exp_q[$];
	logic [15:0] m = 16'hffff;
	logic [7:0] e;
	int error_cnt = 0;
	int checks = 0;
	int seed = 50474;
	always #4 clk_i = ~clk_i;
	lrc_top dut (.clk_i(clk_i), .reset_i(reset_i), .apb_req_i(req), .apb_rsp_o(rsp),
		.rand_read_i(rd), .rand_byte_o(rbyte), .run_control_field_o(run));
	lrc_seq_model seq (.clk_i(clk_i), .go_i(go), .rand_read_o(rd));
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// reference lfsr, msb-first galois, data shifted in from the top
	function automatic logic [15:0] adv(input logic [15:0] s, input logic [7:0] d, input int n);
		logic fb;
		for (int i = 0; i < n; i++) begin
			fb = s[15] ^ d[7];
			d = d << 1;
			s = {s[14:0], 1'b0} ^ (fb ? LRC_POLY : 16'h0000);
		end
		return s;
	endfunction
	// idle cycle at the end so back-to-back calls never double-drive req
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		req <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge clk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (rsp.pready !== 1'b1 && n < 50);
		if (n >= 50) error_cnt++;
		req <= '0;
		@(posedge clk_i);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic rd16();
		rd_chk(LRC_SEED_LOW_OFS, {25'h0, m[7:0]});
		rd_chk(LRC_CRC_HIGH_OFS, {25'h0, m[15:8]});
	endtask
	always @(posedge clk_i) begin
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
			check({rsp.pslverr, rsp.prdata}, exp_q.pop_front());
		end
	end
	task automatic give_verdict();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rd16();
		rd_chk(LRC_RUN_CTRL_OFS, 33'h0);
		$display("reset values done");
		for (int k = 0; k < 4; k++) begin
			e = 8'($random(seed));
			apb(1'b1, LRC_SEED_LOW_OFS, {24'h0, e});
			m = {m[7:0], e};
		end
		rd16();
		$display("seeding done");
		repeat (6) begin
			e = 8'($random(seed));
			apb(1'b1, LRC_CRC_HIGH_OFS, {24'h0, e});
			m = adv(m, e, LRC_CRC_STEPS);
		end
		rd16();
		$display("crc done");
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, LRC_RUN_CTRL_OFS, 32'(r));
			go <= (r != 1);
			@(posedge clk_i);
			go <= 1'b0;
			repeat (3) @(posedge clk_i);
			if (r == 0) m = adv(m, 8'h00, LRC_RAND_STEPS);
			if (r == 1) m = adv(m, 8'h00, 1);
			if (r == 0) check({25'h0, rbyte}, {25'h0, m[7:0]});
			check({31'h0, run}, {31'h0, (r == 1) ? 2'b00 : 2'(r)});
			rd16();
		end
		$display("run modes done");
		rd_chk(12'h00c, {1'b1, 32'h0});
		$display("unmapped done");
		give_verdict();
	end
	initial begin
		#20000;
		error_cnt++;
		give_verdict();
	end
endmodule
`default_nettype wire
